// file: verilog/agic_regs.sv
// wishbone register bank for full-scale adjust and interleave control
//
// The implementer's own choice: the Wishbone slave port.
`timescale 1ns/1ns
`include "agic_cfg.svh"
module agic_regs
   import agic_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [5:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic      [8:0]  q_full_scale_code_o,
   output logic             dual_edge_enable_o,
   output logic             auto_phase_control_o,
   output logic             manual_delay_en_o,
   output logic      [15:0] coarse_delay_o,
   output logic      [15:0] fine_delay_o
);
   ////////////////////////////////////////////////////////////////////////
   logic [15:0] fsadj_q, fsadj_d;
   logic [15:0] ilctl_q, ilctl_d;
   logic [15:0] coarse_q, coarse_d;
   logic [15:0] fine_q, fine_d;
   logic [31:0] dat_q, dat_d;
   logic        ack_q, ack_d;
   agic_mode_t  mode;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0]  sel);
      merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
   endfunction : merge16

   // word index = byte address / 4
   logic [3:0] idx;
   logic       req;
   assign idx = wb_adr_i[5:2];
   assign req = wb_cyc_i & wb_stb_i & ~ack_q;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      fsadj_d  = fsadj_q;
      ilctl_d  = ilctl_q;
      coarse_d = coarse_q;
      fine_d   = fine_q;
      ack_d    = req;
      dat_d    = 32'h00000000;
      if (req && wb_we_i) begin
         // low filler bits stored as written; software keeps them ones
         case (idx)
            `AGIC_IDX_FSADJ:  fsadj_d  = merge16(fsadj_q, wb_dat_i, wb_sel_i);
            `AGIC_IDX_ILCTL:  ilctl_d  = merge16(ilctl_q, wb_dat_i, wb_sel_i);
            `AGIC_IDX_COARSE: coarse_d = merge16(coarse_q, wb_dat_i, wb_sel_i);
            `AGIC_IDX_FINE:   fine_d   = merge16(fine_q, wb_dat_i, wb_sel_i);
            default:          ;
         endcase
      end
      // write-only registers read zero; only status shows state
      if (req && !wb_we_i && idx == `AGIC_IDX_STATUS) begin
         dat_d = {30'h0, ilctl_q[`AGIC_AUTO_PHASE_BIT], ilctl_q[`AGIC_DUAL_EDGE_BIT]};
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fsadj_q  <= `AGIC_FSADJ_RST;
         ilctl_q  <= `AGIC_ILCTL_RST;
         coarse_q <= `AGIC_COARSE_RST;
         fine_q   <= `AGIC_FINE_RST;
         ack_q    <= 1'b0;
         dat_q    <= 32'h00000000;
      end else begin
         fsadj_q  <= fsadj_d;
         ilctl_q  <= ilctl_d;
         coarse_q <= coarse_d;
         fine_q   <= fine_d;
         ack_q    <= ack_d;
         dat_q    <= dat_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered outputs; analog side decodes the code monotonically
   logic [8:0]  fs_q, fs_d;
   logic        dual_edge_q, dual_edge_d;
   logic        auto_phase_q, auto_phase_d;
   logic        man_q, man_d;
   logic [15:0] co_q, co_d;
   logic [15:0] fi_q, fi_d;

   assign mode = ilctl_q[`AGIC_DUAL_EDGE_BIT] ? AGIC_INTERLEAVED : AGIC_DUAL;

   always_comb begin
      fs_d         = fsadj_q[`AGIC_FS_MSB:`AGIC_FS_LSB];
      dual_edge_d  = (mode == AGIC_INTERLEAVED);
      auto_phase_d = ilctl_q[`AGIC_AUTO_PHASE_BIT];
      man_d        = ~ilctl_q[`AGIC_AUTO_PHASE_BIT];
      // manual delays held at zero-adjust values in auto mode, so a
      // stale manual setting never fights the phase detector
      co_d         = ilctl_q[`AGIC_AUTO_PHASE_BIT] ? `AGIC_COARSE_RST : coarse_q;
      fi_d         = ilctl_q[`AGIC_AUTO_PHASE_BIT] ? `AGIC_FINE_RST : fine_q;
   end

   // one extra cycle of latency buys flop-driven outputs
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         fs_q         <= `AGIC_FS_MID;
         dual_edge_q  <= 1'b0;
         auto_phase_q <= 1'b0;
         man_q        <= 1'b1;
         co_q         <= `AGIC_COARSE_RST;
         fi_q         <= `AGIC_FINE_RST;
      end else begin
         fs_q         <= fs_d;
         dual_edge_q  <= dual_edge_d;
         auto_phase_q <= auto_phase_d;
         man_q        <= man_d;
         co_q         <= co_d;
         fi_q         <= fi_d;
      end
   end

   assign q_full_scale_code_o  = fs_q;
   assign dual_edge_enable_o   = dual_edge_q;
   assign auto_phase_control_o = auto_phase_q;
   assign manual_delay_en_o    = man_q;
   assign coarse_delay_o       = co_q;
   assign fine_delay_o         = fi_q;
   assign wb_ack_o             = ack_q;
   assign wb_dat_o             = dat_q;

   ////////////////////////////////////////////////////////////////////////
   // checks sample on the rising edge and rest while reset is held
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // write taken at the full-scale place with both low lanes enabled
   sequence s_fs_write;
      req && wb_we_i && idx == `AGIC_IDX_FSADJ && wb_sel_i[1:0] == 2'h3;
   endsequence

   // write taken at the interleave place with the upper lane enabled
   sequence s_ilctl_high_write;
      req && wb_we_i && idx == `AGIC_IDX_ILCTL && wb_sel_i[1];
   endsequence

   // read taken at the status place
   sequence s_status_read;
      req && !wb_we_i && idx == `AGIC_IDX_STATUS;
   endsequence

   // read taken anywhere else
   sequence s_other_read;
      req && !wb_we_i && idx != `AGIC_IDX_STATUS;
   endsequence

   // manual phase mode, one cycle on so $past sees settled state
   sequence s_manual_mode;
      ##1 !ilctl_q[`AGIC_AUTO_PHASE_BIT];
   endsequence

   a_fs_code_follows: assert property (s_fs_write |-> ##2
      q_full_scale_code_o == $past(wb_dat_i[`AGIC_FS_MSB:`AGIC_FS_LSB], 2))
      else $error("full-scale code does not follow write");

   a_fs_hold: assert property (!(req && wb_we_i && idx == `AGIC_IDX_FSADJ) |-> ##2
      $stable(q_full_scale_code_o))
      else $error("full-scale code moved without write");

   a_dual_edge_follows: assert property (##1
      dual_edge_enable_o == $past(ilctl_q[`AGIC_DUAL_EDGE_BIT]))
      else $error("dual edge output mismatch");

   a_dual_edge_write: assert property (s_ilctl_high_write |-> ##2
      dual_edge_enable_o == $past(wb_dat_i[`AGIC_DUAL_EDGE_BIT], 2))
      else $error("dual edge write not applied");

   a_ilctl_hold: assert property (!(req && wb_we_i && idx == `AGIC_IDX_ILCTL) |-> ##2
      $stable(dual_edge_enable_o) && $stable(auto_phase_control_o))
      else $error("mode bits moved without write");

   a_auto_phase_write: assert property (s_ilctl_high_write |-> ##2
      auto_phase_control_o == $past(wb_dat_i[`AGIC_AUTO_PHASE_BIT], 2))
      else $error("auto phase write not applied");

   a_manual_ignored: assert property (auto_phase_control_o |->
      coarse_delay_o == `AGIC_COARSE_RST && fine_delay_o == `AGIC_FINE_RST)
      else $error("manual delay leaked in auto mode");

   a_phase_excl: assert property (auto_phase_control_o != manual_delay_en_o)
      else $error("auto and manual phase both on");

   a_manual_coarse: assert property (s_manual_mode |=>
      coarse_delay_o == $past(coarse_q))
      else $error("manual coarse delay not applied");

   a_manual_fine: assert property (s_manual_mode |=>
      fine_delay_o == $past(fine_q))
      else $error("manual fine delay not applied");

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack too long");

   a_ack_answer: assert property (req |=> wb_ack_o)
      else $error("no ack");

   a_ack_only_req: assert property (!req |=> !wb_ack_o)
      else $error("ack without request");

   a_status_read: assert property (s_status_read |=>
      wb_dat_o == {30'h0, $past(ilctl_q[`AGIC_AUTO_PHASE_BIT]),
                   $past(ilctl_q[`AGIC_DUAL_EDGE_BIT])})
      else $error("status read wrong");

   a_write_only_zero: assert property (s_other_read |=> wb_dat_o == 32'h0)
      else $error("write-only place read nonzero");

   a_reset_mid: assert property ($fell(rst_i) |->
      q_full_scale_code_o == `AGIC_FS_MID)
      else $error("full-scale code not midpoint after reset");

   a_reset_modes: assert property ($fell(rst_i) |->
      !dual_edge_enable_o && !auto_phase_control_o && manual_delay_en_o)
      else $error("mode bits not cleared by reset");
endmodule : agic_regs

// file: common/agic_cfg.svh
// register map, field positions, reset values for gain/interleave config
`ifndef AGIC_CFG_SVH
`define AGIC_CFG_SVH
`define AGIC_IDX_FSADJ      4'hB
`define AGIC_IDX_ILCTL      4'hD
`define AGIC_IDX_COARSE     4'hE
`define AGIC_IDX_FINE       4'hF
`define AGIC_IDX_STATUS     4'h0
`define AGIC_FS_MSB         15
`define AGIC_FS_LSB         7
`define AGIC_DUAL_EDGE_BIT  15
`define AGIC_AUTO_PHASE_BIT 14
`define AGIC_FSADJ_RST      16'h807F
`define AGIC_ILCTL_RST      16'h3FFF
`define AGIC_COARSE_RST     16'h07FF
`define AGIC_FINE_RST       16'h007F
`define AGIC_FS_MID         9'h100
`endif

// file: common/agic_pkg.sv
// types for gain/interleave config
package agic_pkg;
   typedef enum logic {
      AGIC_DUAL,
      AGIC_INTERLEAVED
   } agic_mode_t;
endpackage : agic_pkg

// file: tb/agic_regs_tb_top.sv
// self-checking bench for the gain and interleave register bank
`timescale 1ns/1ns
module agic_regs_tb_top;
   logic        clk_i       = 1'b0;
   logic        rst_i       = 1'b1;
   logic        cyc         = 1'b0;
   logic        stb         = 1'b0;
   logic        we          = 1'b0;
   logic [5:0]  adr         = 6'h00;
   logic [3:0]  sel         = 4'h0;
   logic [31:0] wdat        = 32'h0;
   logic [31:0] rd;
   logic [31:0] dat_o;
   logic        ack_o;
   logic        dual_edge;
   logic        auto_phase;
   logic        man;
   logic [8:0]  fs;
   logic [15:0] crs, fin;
   int          bad_count   = 0;
   int          comparisons = 0;
   agic_regs uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack_o),
      .q_full_scale_code_o(fs), .dual_edge_enable_o(dual_edge),
      .auto_phase_control_o(auto_phase),
      .manual_delay_en_o(man), .coarse_delay_o(crs), .fine_delay_o(fin));
   initial forever #50 clk_i = ~clk_i;
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // one classic cycle; waits on ack, only the watchdog ends a hang
   task automatic bus(input logic w, input logic [5:0] a, input logic [3:0] s,
                      input logic [31:0] d);
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack_o !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      // config outputs settle one edge after the edge that takes the write
      repeat (2) @(posedge clk_i);
      #1;
   endtask : bus
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4000) @(posedge clk_i);
      bad_count++;
      summarize();
   end
   initial begin
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({23'h0, fs}, 32'h00000100);
      check({29'h0, dual_edge, auto_phase, man}, 32'h00000001);
      check({crs, fin}, 32'h07FF007F);
      bus(1'b1, 6'h2C, 4'hF, 32'h0000FFFF);
      check({23'h0, fs}, 32'h000001FF);
      bus(1'b1, 6'h2C, 4'hF, 32'h0000007F);
      check({23'h0, fs}, 32'h00000000);
      // single lanes: upper byte, then lower byte carrying bit 7
      bus(1'b1, 6'h2C, 4'h2, 32'h0000C000);
      check({23'h0, fs}, 32'h00000180);
      bus(1'b1, 6'h2C, 4'h1, 32'h000000FF);
      check({23'h0, fs}, 32'h00000181);
      bus(1'b1, 6'h38, 4'hF, 32'h00009FFF);
      check({16'h0, crs}, 32'h00009FFF);
      bus(1'b1, 6'h3C, 4'hF, 32'h000000FF);
      check({16'h0, fin}, 32'h000000FF);
      bus(1'b1, 6'h34, 4'hF, 32'h0000BFFF);
      check({29'h0, dual_edge, auto_phase, man}, 32'h00000005);
      bus(1'b0, 6'h00, 4'hF, 32'h0);
      check(rd, 32'h00000001);
      bus(1'b1, 6'h34, 4'hF, 32'h0000FFFF);
      check({13'h0, dual_edge, auto_phase, man, crs}, 32'h000607FF);
      check({16'h0, fin}, 32'h0000007F);
      bus(1'b0, 6'h00, 4'hF, 32'h0);
      check(rd, 32'h00000003);
      bus(1'b1, 6'h34, 4'hF, 32'h00003FFF);
      check({13'h0, dual_edge, auto_phase, man, crs}, 32'h00019FFF);
      check({16'h0, fin}, 32'h000000FF);
      // write-only and unmapped places read back zero
      bus(1'b0, 6'h2C, 4'hF, 32'h0);
      check(rd, 32'h00000000);
      bus(1'b1, 6'h10, 4'hF, 32'h0000FFFF);
      bus(1'b0, 6'h10, 4'hF, 32'h0);
      check(rd, 32'h00000000);
      check({23'h0, fs}, 32'h00000181);
      // reset in mid-run from a non-default state
      bus(1'b1, 6'h34, 4'hF, 32'h0000FFFF);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check({23'h0, fs}, 32'h00000100);
      check({29'h0, dual_edge, auto_phase, man}, 32'h00000001);
      check({crs, fin}, 32'h07FF007F);
      bus(1'b1, 6'h34, 4'hF, 32'h0000BFFF);
      check({13'h0, dual_edge, auto_phase, man, crs}, 32'h000507FF);
      summarize();
   end
endmodule : agic_regs_tb_top
